//--- design/bcis_core.sv
`timescale 1ns/1ps
module bcis_core (
  input  wire logic                           clk_i,
  input  wire logic                           resetn_i,
  input  wire logic [bcis_pkg::INSTR_W-1:0]   instr_i,
  input  wire logic [bcis_pkg::PC_W-1:0]      stack_top_i,
  input  wire logic [bcis_pkg::FADDR_W-1:0]   dbg_addr_i,
  output logic      [bcis_pkg::PC_W-1:0]      pc_o,
  output bcis_pkg::bcis_regs_type             regs_o,
  output logic      [bcis_pkg::DATA_W-1:0]    dbg_data_o,
  output logic                                busy_flush_o
);
  import bcis_pkg::*;

  // ==========================================
  // state
  logic [PC_W-1:0]    pc;
  logic [INSTR_W-1:0] ir;
  logic [DATA_W-1:0]  acc;
  logic [DATA_W-1:0]  option;
  logic               zero;
  logic [DATA_W-1:0]  dbg_data;
  logic [DATA_W-1:0]  file_mem [0:(1<<FADDR_W)-1];
  bcis_state_type     state;
  bcis_state_type     next_state;

  // ==========================================
  // decode
  wire                exec     = (state == ST_RUN);
  wire [FADDR_W-1:0]  faddr    = ir[FADDR_LSB +: FADDR_W];
  wire                dbit     = ir[DEST_BIT];
  wire [DATA_W-1:0]   lit      = ir[LIT_LSB +: DATA_W];
  wire [DATA_W-1:0]   file_rd  = file_mem[faddr];

  wire is_idle   = exec && (ir == IDLE_WORD);
  wire is_cfg    = exec && (ir == CFG_WORD);
  wire is_store  = exec && ((ir & STORE_MASK) == STORE_MATCH);
  wire is_orreg  = exec && ((ir & FD_MASK) == ORREG_MATCH);
  wire is_movreg = exec && ((ir & FD_MASK) == MOVREG_MATCH);
  wire is_incsz  = exec && ((ir & FD_MASK) == INCSZ_MATCH);
  wire is_retlit = exec && ((ir & LIT_MASK) == RETLIT_MATCH);
  wire is_ldlit  = exec && ((ir & LIT_MASK) == LDLIT_MATCH);
  wire is_orlit  = exec && ((ir & LIT_MASK) == ORLIT_MATCH);

  // ==========================================
  // datapath
  wire [DATA_W-1:0] inc_res   = file_rd + BYTE_ONE;
  wire [DATA_W-1:0] orreg_res = acc | file_rd;
  wire [DATA_W-1:0] orlit_res = acc | lit;
  wire              skip      = is_incsz && (inc_res == BYTE_ZERO);
  wire              redirect  = skip || is_retlit;

  // result of the f,d group
  wire [DATA_W-1:0] fd_res = is_incsz ? inc_res :
                             is_orreg ? orreg_res :
                             file_rd;

  wire fd_op   = is_incsz || is_orreg || is_movreg;
  wire file_we = (fd_op && dbit) || is_store;
  wire [DATA_W-1:0] file_wd = is_store ? acc : fd_res;

  wire [DATA_W-1:0] next_acc =
    (fd_op && !dbit)         ? fd_res :
    is_orlit                 ? orlit_res :
    (is_ldlit || is_retlit)  ? lit :
    acc;

  // zero flag only moves for or and move; others keep it
  wire [DATA_W-1:0] z_src = is_orlit ? orlit_res : fd_res;
  wire z_upd = is_orlit || is_orreg || is_movreg;
  wire next_zero = z_upd ? (z_src == BYTE_ZERO) : zero;

  wire [DATA_W-1:0] next_option = is_cfg ? acc : option;

  wire [PC_W-1:0] next_pc = is_retlit ? stack_top_i : pc + PC_STEP;

  // ==========================================
  // flush sequencer
  always_comb begin
    next_state = ST_RUN;
    case (state)
      ST_RUN: begin
        next_state = redirect ? ST_FLUSH : ST_RUN;
      end
      ST_FLUSH: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pc     <= PC_RST;
      ir     <= IDLE_WORD;
      state  <= ST_RUN;
      acc    <= ACC_RST;
      zero   <= ZERO_RST;
      option <= OPTION_RST;
    end else begin
      pc     <= next_pc;
      ir     <= instr_i;
      state  <= next_state;
      acc    <= next_acc;
      zero   <= next_zero;
      option <= next_option;
    end
  end

  // file registers hold data only, no reset
  always_ff @(posedge clk_i) begin
    if (resetn_i && file_we) begin
      file_mem[faddr] <= file_wd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      dbg_data <= DBG_RST;
    end else begin
      dbg_data <= file_mem[dbg_addr_i];
    end
  end

  // ==========================================
  // outputs
  assign pc_o         = pc;
  assign regs_o       = '{option: option, acc: acc, zero: zero};
  assign dbg_data_o   = dbg_data;
  assign busy_flush_o = (state == ST_FLUSH);

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // the discarded slot writes nothing; its effect shows one edge later
  sequence discard_slot_s;
    (state == ST_FLUSH) && !file_we && !z_upd;
  endsequence

  sequence resume_clean_s;
    (state == ST_RUN) && $stable(acc) && $stable(zero) && $stable(option);
  endsequence

  sequence flush_then_run_s;
    discard_slot_s ##1 resume_clean_s;
  endsequence

  incsz_result_a: assert property (
    is_incsz |=> (($past(dbit) ? file_mem[$past(faddr)] : acc) == $past(inc_res))
                 && $stable(zero))
    else $error("increment-skip result or flags wrong");

  incsz_skip_a: assert property (
    skip |=> flush_then_run_s)
    else $error("increment-skip did not discard next instruction");

  incsz_noskip_a: assert property (
    is_incsz && (inc_res != BYTE_ZERO) |=> (state == ST_RUN))
    else $error("increment-skip stalled without zero result");

  orlit_result_a: assert property (
    is_orlit |=> (acc == ($past(acc) | $past(lit))) && (zero == (acc == BYTE_ZERO)))
    else $error("or-literal result or zero flag wrong");

  orreg_result_a: assert property (
    is_orreg |=> (($past(dbit) ? file_mem[$past(faddr)] : acc) == $past(orreg_res))
                 && (zero == ($past(orreg_res) == BYTE_ZERO)))
    else $error("or-register result or zero flag wrong");

  store_acc_a: assert property (
    is_store |=> (file_mem[$past(faddr)] == $past(acc)) && $stable(zero) && $stable(acc))
    else $error("store-accumulator wrong");

  movreg_zero_a: assert property (
    is_movreg |=> (zero == ($past(file_rd) == BYTE_ZERO))
                  && (($past(dbit) ? file_mem[$past(faddr)] : acc) == $past(file_rd)))
    else $error("move-register wrong");

  ldlit_result_a: assert property (
    is_ldlit |=> (acc == $past(lit)) && $stable(zero))
    else $error("load-literal wrong");

  cfg_load_a: assert property (
    is_cfg |=> (option == $past(acc)) && $stable(zero) && $stable(acc))
    else $error("configuration load wrong");

  cfg_hold_a: assert property (
    !is_cfg |=> $stable(option))
    else $error("configuration register changed without load");

  retlit_jump_a: assert property (
    is_retlit |=> (pc == $past(stack_top_i)) && (acc == $past(lit)) && $stable(zero))
    else $error("return-literal wrong");

  retlit_two_a: assert property (
    is_retlit |=> flush_then_run_s)
    else $error("return-literal not two cycles");

  idle_quiet_a: assert property (
    is_idle |=> $stable(acc) && $stable(zero) && $stable(option)
                && (pc == $past(pc) + PC_STEP) && (state == ST_RUN))
    else $error("idle instruction changed state");

  idle_nowrite_a: assert property (
    is_idle |-> !file_we)
    else $error("idle instruction wrote a file register");

  // ==========================================
  // helper: back-to-back flush cycles
  logic [1:0] flush_len;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flush_len <= 2'b00;
    end else if (state == ST_FLUSH) begin
      flush_len <= flush_len + 2'b01;
    end else begin
      flush_len <= 2'b00;
    end
  end

  // ==========================================
  // checks on the flush slot, program counter, flags, accumulator, file writes and sequencer state
  skip_flush_a: assert property (
    skip |=> busy_flush_o)
    else $error("skip did not raise the flush slot");

  retlit_flush_a: assert property (
    is_retlit |=> busy_flush_o)
    else $error("return did not raise the flush slot");

  flush_cause_a: assert property (
    busy_flush_o |-> $past(redirect))
    else $error("flush slot without skip or return");

  flush_nowrite_a: assert property (
    !exec |-> !file_we && !z_upd)
    else $error("discarded instruction had an effect");

  flush_short_a: assert property (
    flush_len <= 2'b01)
    else $error("more than one flush slot in a row");

  skip_resume_a: assert property (
    skip |-> ##2 (pc == $past(pc, 2) + PC_STEP + PC_STEP))
    else $error("skip did not resume after the discarded word");

  retlit_resume_a: assert property (
    is_retlit |-> ##2 (pc == $past(stack_top_i, 2) + PC_STEP))
    else $error("return did not resume at the return address");

  flush_pc_a: assert property (
    !exec |=> (pc == $past(pc) + PC_STEP))
    else $error("program counter stalled in flush slot");

  run_step_a: assert property (
    exec && !is_retlit |=> (pc == $past(pc) + PC_STEP))
    else $error("program counter did not step by one");

  zero_keep_a: assert property (
    !z_upd |=> $stable(zero))
    else $error("zero flag moved without an update");

  zero_track_a: assert property (
    z_upd |=> (zero == ($past(z_src) == BYTE_ZERO)))
    else $error("zero flag does not follow result");

  acc_keep_a: assert property (
    !((fd_op && !dbit) || is_orlit || is_ldlit || is_retlit) |=> $stable(acc))
    else $error("accumulator changed unexpectedly");

  fd_acc_keep_a: assert property (
    fd_op && dbit |=> $stable(acc))
    else $error("file destination changed accumulator");

  fd_file_keep_a: assert property (
    fd_op && !dbit |=> (file_mem[$past(faddr)] == $past(file_rd)))
    else $error("accumulator destination changed file register");

  literal_nowrite_a: assert property (
    is_orlit || is_ldlit || is_retlit || is_cfg || is_idle |-> !file_we)
    else $error("non-file instruction wrote a file register");

  state_onehot_a: assert property (
    $onehot(state))
    else $error("sequencer state not one-hot");
endmodule

//--- design/bcis_pkg.sv
package bcis_pkg;
  // ==========================================
  // widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PC_W    = 9;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned INSTR_W = 12;

  // ==========================================
  // field positions
  localparam int unsigned DEST_BIT  = 5;
  localparam int unsigned FADDR_LSB = 0;
  localparam int unsigned LIT_LSB   = 0;

  // ==========================================
  // instruction patterns: (word & mask) == match; the idle and config words compare whole
  localparam logic [INSTR_W-1:0] IDLE_WORD     = 12'h000;
  localparam logic [INSTR_W-1:0] CFG_WORD      = 12'h002;
  localparam logic [INSTR_W-1:0] STORE_MASK    = 12'hFE0;
  localparam logic [INSTR_W-1:0] STORE_MATCH   = 12'h020;
  localparam logic [INSTR_W-1:0] FD_MASK       = 12'hFC0;
  localparam logic [INSTR_W-1:0] ORREG_MATCH   = 12'h100;
  localparam logic [INSTR_W-1:0] MOVREG_MATCH  = 12'h200;
  localparam logic [INSTR_W-1:0] INCSZ_MATCH   = 12'h3C0;
  localparam logic [INSTR_W-1:0] LIT_MASK      = 12'hF00;
  localparam logic [INSTR_W-1:0] RETLIT_MATCH  = 12'h800;
  localparam logic [INSTR_W-1:0] LDLIT_MATCH   = 12'hC00;
  localparam logic [INSTR_W-1:0] ORLIT_MATCH   = 12'hD00;

  // ==========================================
  // reset values and constants
  localparam logic [PC_W-1:0]   PC_RST     = 9'h000;
  localparam logic [PC_W-1:0]   PC_STEP    = 9'h001;
  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;
  localparam logic [DATA_W-1:0] DBG_RST    = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE   = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic              ZERO_RST   = 1'b0;

  // ==========================================
  // types
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_FLUSH = 2'b10
  } bcis_state_type;

  typedef struct packed {
    logic [DATA_W-1:0] option;
    logic [DATA_W-1:0] acc;
    logic              zero;
  } bcis_regs_type;
endpackage

//--- bench/bcis_prog_mem.sv
`timescale 1ns/1ps
module bcis_prog_mem (
  input  wire logic [bcis_pkg::PC_W-1:0]    pc_i,
  output logic      [bcis_pkg::INSTR_W-1:0] instr_o
);
  import bcis_pkg::*;
  // ==========================================
  // program store, unwritten words fetch as idle
  logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];

  // read in the same cycle as the address
  assign instr_o = mem[pc_i];

  initial begin
    for (int i = 0; i < (1 << PC_W); i++) begin
      mem[i] = IDLE_WORD;
    end
  end
endmodule

//--- bench/bcis_core_test.sv
`timescale 1ns/1ps
module bcis_core_test;
  import bcis_pkg::*;
  // ==========================================
  // signals
  logic               clk_i = 1'b0;
  logic               resetn_i;
  logic [INSTR_W-1:0] instr_i;
  logic [PC_W-1:0]    stack_top_i;
  logic [FADDR_W-1:0] dbg_addr_i;
  logic [PC_W-1:0]    pc_o;
  bcis_regs_type      regs_o;
  logic [DATA_W-1:0]  dbg_data_o;
  logic               busy_flush_o;
  int                 fail_count = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  int                 flush_n = 0;
  int                 fbase;
  int                 wp;

  always #12.5 clk_i = ~clk_i;

  bcis_core uut (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .instr_i      (instr_i),
    .stack_top_i  (stack_top_i),
    .dbg_addr_i   (dbg_addr_i),
    .pc_o         (pc_o),
    .regs_o       (regs_o),
    .dbg_data_o   (dbg_data_o),
    .busy_flush_o (busy_flush_o)
  );

  bcis_prog_mem mem_u (
    .pc_i    (pc_o),
    .instr_o (instr_i)
  );

  // ==========================================
  // helpers
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (busy_flush_o === 1'b1) begin
      flush_n <= flush_n + 1;
    end
    if (cyc == 1000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic regs(input logic [7:0] a, input logic [7:0] o, input logic z);
    chk("acc", {1'b0, a}, {1'b0, regs_o.acc});
    chk("option", {1'b0, o}, {1'b0, regs_o.option});
    chk("zero", {8'h00, z}, {8'h00, regs_o.zero});
  endtask

  task automatic peek(input logic [4:0] a, input logic [7:0] e);
    dbg_addr_i = a;
    @(negedge clk_i);
    chk("file", {1'b0, e}, {1'b0, dbg_data_o});
  endtask

  task automatic put(input logic [INSTR_W-1:0] w);
    mem_u.mem[wp] = w;
    wp++;
  endtask

  // reset, then n rising edges of execution
  task automatic run(input int n);
    @(negedge clk_i);
    resetn_i = 1'b0;
    repeat (20) @(negedge clk_i);
    resetn_i = 1'b1;
    fbase = flush_n;
    repeat (n) @(negedge clk_i);
  endtask

  task automatic clear;
    for (int i = 0; i < (1 << PC_W); i++) begin
      mem_u.mem[i] = IDLE_WORD;
    end
    wp = 0;
  endtask

  // ==========================================
  // scenarios
  task automatic t_literal;
    clear();
    put(12'hC00); put(12'hD00); put(12'hC7F); put(12'h002);
    run(10);
    regs(8'h7F, 8'h7F, 1'b1);
    chk("pc", 9'h00A, pc_o);
    chk("flushes", 9'h000, 9'(flush_n - fbase));
  endtask

  task automatic t_or_clear;
    clear();
    put(12'hC00); put(12'hD00); put(12'hC5A); put(12'hDA5);
    run(8);
    regs(8'hFF, 8'hFF, 1'b0);
  endtask

  task automatic t_file;
    clear();
    put(12'hC81); put(12'h023); put(12'h03F); put(12'hC0E); put(12'h123);
    put(12'h203); put(12'hC00); put(12'h03E); put(12'hC11); put(12'h23E);
    run(14);
    regs(8'h11, 8'hFF, 1'b1);
    peek(5'd3, 8'h8F);
    peek(5'd31, 8'h81);
    peek(5'd30, 8'h00);
  endtask

  task automatic t_skip;
    clear();
    put(12'hC00); put(12'hD00); put(12'hCFF); put(12'h025); put(12'hC10);
    put(12'h026); put(12'h3C6); put(12'h3E5); put(12'hC77); put(12'h002);
    run(14);
    regs(8'h11, 8'h11, 1'b1);
    chk("flushes", 9'h001, 9'(flush_n - fbase));
    peek(5'd5, 8'h00);
    peek(5'd6, 8'h10);
  endtask

  task automatic t_skip_acc;
    clear();
    put(12'hCF0);
    put(12'h028);
    put(12'hC0F);
    put(12'h108);
    put(12'h027);
    put(12'h3C7);
    put(12'hC55);
    put(12'h002);
    run(12);
    regs(8'h00, 8'h00, 1'b0);
    chk("flushes", 9'h001, 9'(flush_n - fbase));
    peek(5'd7, 8'hFF);
    peek(5'd8, 8'hF0);
  endtask

  task automatic t_return;
    clear();
    put(12'hC00); put(12'hD00); put(12'h8A5); put(12'hC11);
    wp = 64;
    put(12'h002);
    run(10);
    regs(8'hA5, 8'hA5, 1'b1);
    chk("pc", 9'h046, pc_o);
    chk("flushes", 9'h001, 9'(flush_n - fbase));
  endtask

  // ==========================================
  // sequence and verdict
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    resetn_i = 1'b0;
    dbg_addr_i = 5'd0;
    stack_top_i = 9'h040;
    repeat (20) @(negedge clk_i);
    t_literal();
    t_or_clear();
    t_file();
    t_skip();
    t_skip_acc();
    t_return();
    finish_test();
  end
endmodule
